// ===== design/can_rx_flag_irq_enable.sv
// Purpose: receive flags, status fields and receive interrupt enables
// Assumes: single core clock, synchronous active-low reset, AXI4-Lite slave
// Notes: sleep, wake and error counter inputs come from synchronous logic;
//   only the bus activity pin is synchronised here
// Operation
// R1: overrun sets flag bit 1; error interrupt while flag and enable set.
// R2: full flag bit 0 sets when a message enters the foreground buffer.
// R3: foreground buffer loads only for accepted, crc-good, error-free frames.
// R4: host clears the full flag after reading the foreground buffer.
// R5: no new message loads while the full flag is set.
// R6: receive interrupt pending while full flag set and not masked.
// R7: receiver reports bus-off above 255 tx errors, then jumps to ok.
// R8: enable register held at reset value during initialization mode.
// R9: sensitivity fields survive initialization mode.
// R10: enables always readable; writable only outside initialization mode.
// R11: enable bit 7 gates the wake-up interrupt.
// R12: enable bit 6 gates status-change onto the error interrupt.
// R13: receiver sensitivity bits 5:4 choose which receiver changes interrupt.
// R14: transmitter sensitivity bits 3:2 use the same coding.
// R15: status fields track real state, updating only with no change pending.
// R16: enable bit 1 gates overrun onto the error interrupt.
// R17: enable bit 0 gates the receive-full interrupt.
// R18: host should not read receive buffer while full flag clear.
// R19: host sets wake-up enables to recover from stop or wait.
// R20: writing 1 clears a flag outside init; status fields read-only.
// R21: receiver state 00 up to 96, 01 to 127, 10 above, 11 bus-off.
// R22: wake flag sets on bus activity in sleep with wake function on.
// R23: status-change flag freezes status fields until cleared.
// R24: interrupt outputs are flag AND enable, error ORs overrun and change.
module can_rx_flag_irq_enable (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // protocol engine side
  input wire logic overrun_event_i,
  input wire logic msg_valid_i,
  input wire logic msg_good_i,
  input wire logic [8:0] rx_error_count_i,
  input wire logic [8:0] tx_error_count_i,
  input wire logic tx_bus_off_i,
  input wire logic sleep_mode_i,
  input wire logic bus_activity_i,
  input wire logic init_acknowledge_i,
  output logic queue_ready_o,
  output logic fg_load_o,
  output logic init_request_o,
  output logic wakeup_function_enable_o,
  output logic rx_irq_o,
  output logic err_irq_o,
  output logic wakeup_irq_o
);
  typedef enum logic [1:0] {w_idle, w_resp} wr_state_type;

  logic [7:0] enables;
  logic [1:0] receiver_change_sensitivity;
  logic [1:0] transmitter_change_sensitivity;
  logic wakeup_flag, status_change_flag, overrun_flag, rx_buffer_full_flag;
  logic [1:0] receiver_state, transmitter_state;
  logic [1:0] next_receiver_state, next_transmitter_state;
  logic change_event;
  logic activity_meta, activity_sync;
  logic init_mode;
  logic aw_held, w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [7:0] wbyte;
  logic [7:0] flags_read;
  wr_state_type wr_state;
  logic load;

  // initialization mode only when both handshake bits are high
  assign init_mode = init_request_o && init_acknowledge_i;
  assign wr_fire = aw_held && w_held && (wr_state == w_idle);
  assign wbyte = w_strb[0] ? w_data[7:0] : 8'h00;
  assign flags_read = {wakeup_flag, status_change_flag, receiver_state,
                       transmitter_state, overrun_flag, rx_buffer_full_flag};

  // bus activity pin is asynchronous; two stages before use
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      activity_meta <= 1'b0;
      activity_sync <= 1'b0;
    end else begin
      activity_meta <= bus_activity_i;
      activity_sync <= activity_meta;
    end
  end

  can_rx_foreground can_rx_foreground_i (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .msg_valid_i(msg_valid_i),
    .msg_good_i(msg_good_i),
    .full_flag_i(rx_buffer_full_flag),
    .queue_ready_o(),
    .load_o(load)
  );

  can_rx_state_track can_rx_state_track_i (
    .rx_count_i(rx_error_count_i),
    .tx_count_i(tx_error_count_i),
    .tx_bus_off_i(tx_bus_off_i),
    .receiver_state_i(receiver_state),
    .transmitter_state_i(transmitter_state),
    .receiver_change_sensitivity_i(receiver_change_sensitivity),
    .transmitter_change_sensitivity_i(transmitter_change_sensitivity),
    .next_receiver_state_o(next_receiver_state),
    .next_transmitter_state_o(next_transmitter_state),
    .change_event_o(change_event)
  );

  // write address and data may arrive in either order
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      wr_state <= w_idle;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= can_rx_flag_pkg::resp_okay;
    end else begin
      case (wr_state)
        w_idle: begin
          if (wr_fire) begin
            wr_state <= w_resp;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr[3:2] == can_rx_flag_pkg::counters_offset[3:2]) ?
                           can_rx_flag_pkg::resp_slverr : can_rx_flag_pkg::resp_okay;
          end
        end
        w_resp: begin
          if (s_axi_bready) begin
            wr_state <= w_idle;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: wr_state <= w_idle;
      endcase
    end
  end

  // control register: init request and wake function enable
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      init_request_o <= 1'b1;
      wakeup_function_enable_o <= 1'b0;
    end else if (wr_fire && aw_addr == can_rx_flag_pkg::control_offset && w_strb[0]) begin
      init_request_o <= w_data[0];
      wakeup_function_enable_o <= w_data[1]; // see R19
    end
  end

  // enable bits cleared in init; sensitivity fields kept
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      enables <= can_rx_flag_pkg::enables_reset;
      receiver_change_sensitivity <= can_rx_flag_pkg::sens_reset;
      transmitter_change_sensitivity <= can_rx_flag_pkg::sens_reset;
    end else if (init_mode) begin
      enables <= can_rx_flag_pkg::enables_reset; // see R8
    end else if (wr_fire && aw_addr == can_rx_flag_pkg::enables_offset && w_strb[0]) begin
      enables <= w_data[7:0]; // see R10
      receiver_change_sensitivity <= w_data[can_rx_flag_pkg::rx_sens_lo +: 2]; // see R9
      transmitter_change_sensitivity <= w_data[can_rx_flag_pkg::tx_sens_lo +: 2];
    end
  end

  // flags: wake, overrun and full sets win over a write-one clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || init_mode) begin
      wakeup_flag <= 1'b0;
      status_change_flag <= 1'b0;
      overrun_flag <= 1'b0;
      rx_buffer_full_flag <= 1'b0;
    end else begin
      if (wr_fire && aw_addr == can_rx_flag_pkg::flags_offset) begin
        if (wbyte[can_rx_flag_pkg::wakeup_bit]) wakeup_flag <= 1'b0; // see R20
        if (wbyte[can_rx_flag_pkg::status_change_bit]) status_change_flag <= 1'b0;
        if (wbyte[can_rx_flag_pkg::overrun_bit]) overrun_flag <= 1'b0;
        if (wbyte[can_rx_flag_pkg::full_bit]) rx_buffer_full_flag <= 1'b0; // see R4
      end
      if (sleep_mode_i && wakeup_function_enable_o && activity_sync) begin
        wakeup_flag <= 1'b1; // see R22
      end
      if (change_event && !status_change_flag) begin
        status_change_flag <= 1'b1;
      end
      if (overrun_event_i) begin
        overrun_flag <= 1'b1; // see R1
      end
      if (load) begin
        rx_buffer_full_flag <= 1'b1; // see R2
      end
    end
  end

  // status fields frozen while a change is pending; kept through init
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      receiver_state <= can_rx_flag_pkg::state_ok;
      transmitter_state <= can_rx_flag_pkg::state_ok;
    end else if (!status_change_flag) begin
      receiver_state <= next_receiver_state; // see R15 see R23
      transmitter_state <= next_transmitter_state;
    end
  end

  // interrupt and handshake outputs, all registered
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rx_irq_o <= 1'b0;
      err_irq_o <= 1'b0;
      wakeup_irq_o <= 1'b0;
      queue_ready_o <= 1'b0;
      fg_load_o <= 1'b0;
    end else begin
      rx_irq_o <= rx_buffer_full_flag && enables[can_rx_flag_pkg::full_bit]; // see R6 see R17 see R24
      err_irq_o <= (overrun_flag && enables[can_rx_flag_pkg::overrun_bit]) || // see R16
                   (status_change_flag && enables[can_rx_flag_pkg::status_change_bit]); // see R12
      wakeup_irq_o <= wakeup_flag && enables[can_rx_flag_pkg::wakeup_bit]; // see R11
      queue_ready_o <= !rx_buffer_full_flag && !load; // see R5
      fg_load_o <= load;
    end
  end

  // read channel: one cycle to rvalid, held until rready
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= can_rx_flag_pkg::resp_okay;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= can_rx_flag_pkg::resp_okay;
        case (s_axi_araddr)
          can_rx_flag_pkg::flags_offset: s_axi_rdata <= {24'h000000, flags_read};
          can_rx_flag_pkg::enables_offset: s_axi_rdata <= {24'h000000,
            enables[7:6], receiver_change_sensitivity, transmitter_change_sensitivity,
            enables[1:0]};
          can_rx_flag_pkg::control_offset: s_axi_rdata <= {28'h0000000, init_mode,
            init_acknowledge_i, wakeup_function_enable_o, init_request_o};
          can_rx_flag_pkg::counters_offset: s_axi_rdata <= {7'h00, tx_error_count_i,
            7'h00, rx_error_count_i};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= can_rx_flag_pkg::resp_slverr;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ===== design/can_rx_flag_pkg.sv
// Purpose: shared constants for the receive flag and interrupt enable block
// Assumes: 50 MHz core clock, AXI4-Lite register access, 32-bit data
// Notes: offsets are byte addresses of aligned words
package can_rx_flag_pkg;
  localparam logic [3:0] flags_offset = 4'h0;
  localparam logic [3:0] enables_offset = 4'h4;
  localparam logic [3:0] control_offset = 4'h8;
  localparam logic [3:0] counters_offset = 4'hC;
  // flag bit positions
  localparam int wakeup_bit = 7;
  localparam int status_change_bit = 6;
  localparam int overrun_bit = 1;
  localparam int full_bit = 0;
  // enable bit positions and fields
  localparam int rx_sens_lo = 4;
  localparam int tx_sens_lo = 2;
  localparam logic [7:0] flags_reset = 8'h00;
  localparam logic [7:0] enables_reset = 8'h00;
  localparam logic [1:0] sens_reset = 2'h0;
  // state encodings of the status fields
  localparam logic [1:0] state_ok = 2'h0;
  localparam logic [1:0] state_warning = 2'h1;
  localparam logic [1:0] state_error = 2'h2;
  localparam logic [1:0] state_bus_off = 2'h3;
  // sensitivity codes
  localparam logic [1:0] sens_none = 2'h0;
  localparam logic [1:0] sens_bus_off = 2'h1;
  localparam logic [1:0] sens_error = 2'h2;
  localparam logic [1:0] sens_all = 2'h3;
  // error counter thresholds
  localparam logic [8:0] warning_limit = 9'h060;
  localparam logic [8:0] error_limit = 9'h07F;
  localparam logic [8:0] bus_off_limit = 9'h0FF;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// ===== design/can_rx_state_track.sv
// Purpose: maps error counters to state codes and judges status changes
// Assumes: counters come from the protocol engine on the same clock
// Notes: purely combinational
module can_rx_state_track (
  input wire logic [8:0] rx_count_i,
  input wire logic [8:0] tx_count_i,
  input wire logic tx_bus_off_i,
  input wire logic [1:0] receiver_state_i,
  input wire logic [1:0] transmitter_state_i,
  input wire logic [1:0] receiver_change_sensitivity_i,
  input wire logic [1:0] transmitter_change_sensitivity_i,
  output logic [1:0] next_receiver_state_o,
  output logic [1:0] next_transmitter_state_o,
  output logic change_event_o
);
  // a change counts when either end state lies in the selected band
  function automatic logic counts(input logic [1:0] sens, input logic [1:0] a,
                                  input logic [1:0] b);
    logic hit;
    hit = 1'b0;
    case (sens)
      can_rx_flag_pkg::sens_none: hit = 1'b0;
      can_rx_flag_pkg::sens_bus_off: hit = (a == can_rx_flag_pkg::state_bus_off) ||
                                           (b == can_rx_flag_pkg::state_bus_off);
      can_rx_flag_pkg::sens_error: hit = a[1] || b[1];
      default: hit = 1'b1;
    endcase
    return (a != b) && hit;
  endfunction

  function automatic logic [1:0] band(input logic [8:0] cnt);
    if (cnt <= can_rx_flag_pkg::warning_limit) return can_rx_flag_pkg::state_ok;
    else if (cnt <= can_rx_flag_pkg::error_limit) return can_rx_flag_pkg::state_warning;
    else return can_rx_flag_pkg::state_error;
  endfunction

  // receiver reports bus-off too; leaving bus-off drops straight to ok
  always_comb begin
    if (tx_bus_off_i) begin
      next_receiver_state_o = can_rx_flag_pkg::state_bus_off; // see R7
      next_transmitter_state_o = can_rx_flag_pkg::state_bus_off;
    end else if (receiver_state_i == can_rx_flag_pkg::state_bus_off) begin
      next_receiver_state_o = can_rx_flag_pkg::state_ok; // see R7
      next_transmitter_state_o = band(tx_count_i);
    end else begin
      next_receiver_state_o = band(rx_count_i); // see R21
      next_transmitter_state_o = band(tx_count_i);
    end
    change_event_o = counts(receiver_change_sensitivity_i, receiver_state_i,
                            next_receiver_state_o) || // see R13
                     counts(transmitter_change_sensitivity_i, transmitter_state_i,
                            next_transmitter_state_o); // see R14
  end
endmodule

// ===== design/can_rx_foreground.sv
// Purpose: hands queued messages into the foreground buffer slot
// Assumes: queue and engine on the core clock
// Notes: load pulse only when slot free and message was good
module can_rx_foreground (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic msg_valid_i,
  input wire logic msg_good_i,
  input wire logic full_flag_i,
  output logic queue_ready_o,
  output logic load_o
);
  // slot is free only while the full flag is clear
  always_comb begin
    queue_ready_o = !full_flag_i; // see R5
  end

  // bad frames are dropped without loading the slot
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      load_o <= 1'b0;
    end else begin
      load_o <= msg_valid_i && msg_good_i && !full_flag_i && !load_o; // see R3
    end
  end
endmodule

// ===== dv/can_rx_engine_model.sv
// Purpose: protocol engine and receive queue stand-in
// Assumes: bench posts one message at a time on the core clock
// Notes: msg_good_o toggles while nothing is offered, so it carries no stale value
module can_rx_engine_model (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic post_i,
  input wire logic post_good_i,
  input wire logic fg_load_i,
  output logic msg_valid_o,
  output logic msg_good_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // offer held until the slot takes it; a bad frame is dropped by the queue itself
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      msg_valid_o <= 1'b0;
      msg_good_o <= 1'b0;
    end else if (post_i) begin
      msg_valid_o <= 1'b1;
      msg_good_o <= post_good_i;
    end else if (msg_valid_o && (fg_load_i || !msg_good_o)) begin
      msg_valid_o <= 1'b0;
    end else if (!msg_valid_o) begin
      msg_good_o <= ~msg_good_o;
    end
  end
endmodule

// ===== dv/can_rx_flag_irq_enable_chk.sv
// Purpose: port-level assertions for the receive flag and enable block
// Assumes: one core clock, synchronous active-low reset
// Notes: irq outputs lag the flags by one cycle, so bounds allow for it
module can_rx_flag_irq_chk (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic msg_valid_i,
  input wire logic msg_good_i,
  input wire logic init_acknowledge_i,
  input wire logic queue_ready_o,
  input wire logic fg_load_o,
  input wire logic init_request_o,
  input wire logic rx_irq_o,
  input wire logic err_irq_o,
  input wire logic wakeup_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // bus handshakes as steps
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_load_good:
    assert property (fg_load_o |-> $past(msg_valid_i && msg_good_i)
      || $past(msg_valid_i && msg_good_i, 2)) else $error("load without good message");
  a_one_load:
    assert property (fg_load_o |=> !fg_load_o [*2]) else $error("second load too soon");
  a_slot_taken:
    assert property (fg_load_o |-> ##[0:1] !queue_ready_o) else $error("slot still free");
  a_rx_irq_full:
    assert property ($rose(rx_irq_o) |-> !queue_ready_o) else $error("rx irq with slot free");
  a_init_quiet:
    assert property ((init_request_o && init_acknowledge_i) [*3]
      |-> !rx_irq_o && !err_irq_o && !wakeup_irq_o) else $error("irq in init mode");
  a_write_answer:
    assert property (wr_taken |-> ##[1:3] s_axi_bvalid) else $error("no write response");
  a_read_answer:
    assert property (rd_taken |-> ##[1:2] s_axi_rvalid) else $error("no read data");
  a_bvalid_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
  a_rvalid_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule
bind can_rx_flag_irq_enable can_rx_flag_irq_chk can_rx_flag_irq_chk_i (.core_clk_i, .reset_n_i,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .msg_valid_i, .msg_good_i, .init_acknowledge_i, .queue_ready_o, .fg_load_o, .init_request_o,
  .rx_irq_o, .err_irq_o, .wakeup_irq_o);

// ===== dv/can_rx_flag_irq_enable_bench.sv
// Purpose: self-checking bench for the receive flag and enable block
// Assumes: AXI4-Lite master tasks, engine model on the far side
// Notes: error counters are driven directly; no randomness
module can_rx_flag_irq_enable_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] flg = can_rx_flag_pkg::flags_offset;
  localparam logic [3:0] enr = can_rx_flag_pkg::enables_offset;
  localparam logic [3:0] ctl = can_rx_flag_pkg::control_offset;
  logic core_clk_i = 1'b0;
  logic reset_n_i, post, post_good;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, overrun_event_i;
  logic msg_valid_i, msg_good_i, tx_bus_off_i, sleep_mode_i, bus_activity_i;
  logic init_acknowledge_i, queue_ready_o, fg_load_o, init_request_o;
  logic wakeup_function_enable_o, rx_irq_o, err_irq_o, wakeup_irq_o;
  logic [8:0] rx_error_count_i, tx_error_count_i;
  int err_count = 0;
  int checks_done = 0;
  int loads = 0;
  // status-change cases: enables, counts, bus-off, expected flags
  logic [7:0] en_t [10] = '{8'h40, 8'h50, 8'h60, 8'h70, 8'h60, 8'h50, 8'h50, 8'h0C, 8'h44, 8'h48};
  logic [8:0] rc_t [10] = '{9'h064, 9'h064, 9'h064, 9'h064, 9'h082, 9'h082, '0, '0, '0, '0};
  logic [8:0] tc_t [10] = '{'0, '0, '0, '0, '0, '0, 9'h100, 9'h064, 9'h064, 9'h082};
  logic bo_t [10] = '{'0, '0, '0, '0, '0, '0, 1'b1, '0, '0, '0};
  logic [7:0] ex_t [10] = '{8'h10, 8'h10, 8'h10, 8'h50, 8'h60, 8'h20, 8'h7C, 8'h44, 8'h04, 8'h48};
  always #10 core_clk_i = ~core_clk_i;
  can_rx_flag_irq_enable can_rx_flag_irq_enable_i (.core_clk_i, .reset_n_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .overrun_event_i, .msg_valid_i,
    .msg_good_i, .rx_error_count_i, .tx_error_count_i, .tx_bus_off_i, .sleep_mode_i,
    .bus_activity_i, .init_acknowledge_i, .queue_ready_o, .fg_load_o, .init_request_o,
    .wakeup_function_enable_o, .rx_irq_o, .err_irq_o, .wakeup_irq_o);
  can_rx_engine_model can_rx_engine_model_i (.core_clk_i, .reset_n_i, .post_i(post),
    .post_good_i(post_good), .fg_load_i(fg_load_o), .msg_valid_o(msg_valid_i),
    .msg_good_o(msg_good_i));
  // count slot loads seen at the ports
  always @(posedge core_clk_i) if (fg_load_o === 1'b1) loads++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // address and data offered together, each released when taken
  task automatic axw(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge core_clk_i);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk_i); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, r);
    // one quiet edge, so a following call never re-raises bready in this step
    @(posedge core_clk_i);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk_i); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rresp, can_rx_flag_pkg::resp_okay);
    chk(s_axi_rdata, {24'h000000, e});
  endtask
  task automatic send(input logic g);
    post <= 1'b1;
    post_good <= g;
    @(posedge core_clk_i);
    post <= 1'b0;
    idle(6);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_count++;
    conclude();
  end
  // main sequence
  initial begin
    {reset_n_i, post, post_good, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h00;
    {s_axi_arvalid, s_axi_rready, overrun_event_i, tx_bus_off_i, sleep_mode_i} = 5'h00;
    {bus_activity_i, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {rx_error_count_i, tx_error_count_i} = '0;
    s_axi_wstrb = 4'hF;
    init_acknowledge_i = 1'b1;
    idle(16);
    reset_n_i <= 1'b1;
    rdchk(flg, 8'h00);
    axw(enr, 8'hFF, can_rx_flag_pkg::resp_okay);
    rdchk(enr, 8'h00);
    axw(ctl, 8'h00, can_rx_flag_pkg::resp_okay);
    chk(init_request_o, 1'b0);
    init_acknowledge_i <= 1'b0;
    axw(enr, 8'h01, can_rx_flag_pkg::resp_okay);
    send(1'b1);
    rdchk(flg, 8'h01);
    chk(rx_irq_o, 1'b1);
    chk(queue_ready_o, 1'b0);
    send(1'b1);
    chk(loads, 1);
    axw(flg, 8'h00, can_rx_flag_pkg::resp_okay);
    rdchk(flg, 8'h01);
    axw(flg, 8'h01, can_rx_flag_pkg::resp_okay);
    idle(6);
    chk(loads, 2);
    axw(enr, 8'h00, can_rx_flag_pkg::resp_okay);
    idle(3);
    chk(rx_irq_o, 1'b0);
    axw(flg, 8'h01, can_rx_flag_pkg::resp_okay);
    send(1'b0);
    chk(loads, 2);
    rdchk(flg, 8'h00);
    axw(enr, 8'h02, can_rx_flag_pkg::resp_okay);
    overrun_event_i <= 1'b1;
    idle(1);
    overrun_event_i <= 1'b0;
    idle(4);
    rdchk(flg, 8'h02);
    chk(err_irq_o, 1'b1);
    axw(enr, 8'h00, can_rx_flag_pkg::resp_okay);
    idle(3);
    chk(err_irq_o, 1'b0);
    axw(flg, 8'h02, can_rx_flag_pkg::resp_okay);
    // each case starts from ok with the flags clear and sensitivity off
    for (int i = 0; i < 10; i++) begin
      axw(enr, en_t[i], can_rx_flag_pkg::resp_okay);
      rx_error_count_i <= rc_t[i];
      tx_error_count_i <= tc_t[i];
      tx_bus_off_i <= bo_t[i];
      idle(4);
      rdchk(flg, ex_t[i]);
      chk(err_irq_o, ex_t[i][6] & en_t[i][6]);
      rx_error_count_i <= 9'h000;
      tx_error_count_i <= 9'h000;
      tx_bus_off_i <= 1'b0;
      idle(4);
      axw(flg, 8'h3C, can_rx_flag_pkg::resp_okay);
      rdchk(flg, ex_t[i][6] ? ex_t[i] : 8'h00);
      axw(enr, 8'h00, can_rx_flag_pkg::resp_okay);
      axw(flg, 8'hC3, can_rx_flag_pkg::resp_okay);
      idle(3);
      rdchk(flg, 8'h00);
    end
    axw(enr, 8'h80, can_rx_flag_pkg::resp_okay);
    axw(ctl, 8'h02, can_rx_flag_pkg::resp_okay);
    chk(wakeup_function_enable_o, 1'b1);
    rdchk(ctl, 8'h02);
    sleep_mode_i <= 1'b1;
    bus_activity_i <= 1'b1;
    idle(2);
    bus_activity_i <= 1'b0;
    idle(6);
    rdchk(flg, 8'h80);
    chk(wakeup_irq_o, 1'b1);
    axw(enr, 8'h00, can_rx_flag_pkg::resp_okay);
    idle(3);
    chk(wakeup_irq_o, 1'b0);
    sleep_mode_i <= 1'b0;
    axw(flg, 8'h80, can_rx_flag_pkg::resp_okay);
    rdchk(flg, 8'h00);
    axw(enr, 8'hFF, can_rx_flag_pkg::resp_okay);
    rdchk(enr, 8'hFF);
    axw(ctl, 8'h01, can_rx_flag_pkg::resp_okay);
    init_acknowledge_i <= 1'b1;
    idle(4);
    rdchk(enr, 8'h3C);
    rdchk(ctl, 8'h0D);
    axw(4'hC, 8'hFF, can_rx_flag_pkg::resp_slverr);
    conclude();
  end
endmodule
